// [pkg/dop_pkg.sv]
// Constants and types shared by the digital output pattern ports
package dop_pkg;

   // ==========================================================
   // Port geometry
   localparam int PORT_COUNT = 4;
   localparam int PORT_WIDTH = 8;
   localparam int LINE_COUNT = PORT_COUNT * PORT_WIDTH;
   localparam int CHAN_WIDTH = 5;
   localparam int IDX_WIDTH  = 2;
   localparam int BYTE_SHIFT = 3;

   // ==========================================================
   // Channel numbers
   localparam logic [CHAN_WIDTH-1:0] CHAN_FIRST  = 5'h0B;
   localparam logic [CHAN_WIDTH-1:0] CHAN_THIRD  = 5'h0D;
   localparam logic [CHAN_WIDTH-1:0] CHAN_LAST   = 5'h0E;

   // ==========================================================
   // Reset values and data masks
   localparam logic [PORT_WIDTH-1:0] PATTERN_RESET = 8'h00;
   localparam logic [PORT_COUNT-1:0] DIR_RESET     = 4'h0;
   localparam logic [LINE_COUNT-1:0] MASK_BYTE     = 32'h0000_00FF;
   localparam logic [LINE_COUNT-1:0] MASK_PAIR     = 32'h0000_FFFF;
   localparam logic [LINE_COUNT-1:0] MASK_ALL      = 32'hFFFF_FFFF;
   localparam logic [PORT_COUNT-1:0] SEL_BYTE      = 4'h1;
   localparam logic [PORT_COUNT-1:0] SEL_PAIR      = 4'h3;
   localparam logic [PORT_COUNT-1:0] SEL_ALL       = 4'hF;

   // ==========================================================
   // Panel value entry
   localparam int ACC_WIDTH = 12;
   localparam logic [4:0]           RADIX_DEC = 5'h0A;
   localparam logic [4:0]           RADIX_HEX = 5'h10;
   localparam logic [4:0]           RADIX_OCT = 5'h08;
   localparam logic [ACC_WIDTH-1:0] PANEL_MAX = 12'h0FF;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      WRITE_PORT_BYTE_CMD,
      WRITE_PORT_PAIR_CMD,
      WRITE_ALL_PORTS_CMD,
      WRITE_NONE_CMD
   } dop_op_t;

   typedef enum logic [1:0] {
      FMT_DEC,
      FMT_HEX,
      FMT_BIN,
      FMT_OCT
   } dop_fmt_t;

   typedef enum {
      PNL_IDLE,
      PNL_ENTRY
   } dop_pnl_state_t;

endpackage

// [logic/dop_output_ports.sv]
// Output pattern logic for the four 8-bit digital output ports
`timescale 1ns/100ps

module dop_output_ports (
   // Clock and reset
   input  wire logic                                    mclk,
   input  wire logic                                    rst,
   // Port direction configuration
   input  wire logic                                    cfgValid,
   input  wire logic [dop_pkg::CHAN_WIDTH-1:0]          cfgChan,
   input  wire logic                                    cfgOutput,
   // Remote write command
   input  wire logic                                    remValid,
   input  wire dop_pkg::dop_op_t                        remOp,
   input  wire logic [dop_pkg::CHAN_WIDTH-1:0]          remChan,
   input  wire logic [dop_pkg::LINE_COUNT-1:0]          remData,
   output logic                                         remAck,
   output logic                                         remErr,
   // Panel entry
   input  wire logic                                    panelFmtValid,
   input  wire dop_pkg::dop_fmt_t                       panelFmtSel,
   input  wire logic                                    panelDigitValid,
   input  wire logic [3:0]                              panelDigit,
   input  wire logic                                    panelClear,
   input  wire logic                                    panelEnter,
   input  wire logic [dop_pkg::CHAN_WIDTH-1:0]          panelChan,
   input  wire logic                                    resetCmd,
   output logic                                         panelAck,
   output logic                                         panelErr,
   output dop_pkg::dop_fmt_t                            panelFmt,
   output logic [dop_pkg::PORT_WIDTH-1:0]               panelValue,
   // Output lines
   output logic [dop_pkg::LINE_COUNT-1:0]               lineOut,
   output logic [dop_pkg::LINE_COUNT-1:0]               lineOe
);

   // ==========================================================
   // Channel decoding
   function automatic logic chanInRange(input logic [dop_pkg::CHAN_WIDTH-1:0] chan);
      chanInRange = (chan >= dop_pkg::CHAN_FIRST) && (chan <= dop_pkg::CHAN_LAST);
   endfunction

   function automatic logic [dop_pkg::IDX_WIDTH-1:0] chanIndex(
      input logic [dop_pkg::CHAN_WIDTH-1:0] chan);
      logic [dop_pkg::CHAN_WIDTH-1:0] diff;
      diff      = chan - dop_pkg::CHAN_FIRST;
      chanIndex = diff[dop_pkg::IDX_WIDTH-1:0];
   endfunction

   // ==========================================================
   // State
   logic [dop_pkg::PORT_WIDTH-1:0] pattern_q [dop_pkg::PORT_COUNT];
   logic [dop_pkg::PORT_COUNT-1:0] dirOut_q;
   dop_pkg::dop_fmt_t              fmt_q;
   logic [dop_pkg::PORT_WIDTH-1:0] acc_q;
   logic [dop_pkg::PORT_WIDTH-1:0] acc_d;
   dop_pkg::dop_pnl_state_t        pnl_q;
   dop_pkg::dop_pnl_state_t        pnl_d;

   // ==========================================================
   // Remote command decode
   logic [dop_pkg::IDX_WIDTH-1:0]  remIdx;
   logic [dop_pkg::PORT_COUNT-1:0] remSel;
   logic [dop_pkg::LINE_COUNT-1:0] remMask;
   logic [dop_pkg::LINE_COUNT-1:0] remLines;
   logic                           remChanOk;
   logic                           remOk;

   always_comb begin
      remIdx    = chanIndex(remChan);
      remChanOk = 1'b0;
      remSel    = '0;
      remMask   = '0;
      case (remOp)
         dop_pkg::WRITE_PORT_BYTE_CMD: begin
            remChanOk = chanInRange(remChan);
            remSel    = dop_pkg::SEL_BYTE;
            remMask   = dop_pkg::MASK_BYTE;
         end
         dop_pkg::WRITE_PORT_PAIR_CMD: begin
            remChanOk = (remChan == dop_pkg::CHAN_FIRST)
                        || (remChan == dop_pkg::CHAN_THIRD);
            remSel    = dop_pkg::SEL_PAIR;
            remMask   = dop_pkg::MASK_PAIR;
         end
         dop_pkg::WRITE_ALL_PORTS_CMD: begin
            remChanOk = (remChan == dop_pkg::CHAN_FIRST);
            remSel    = dop_pkg::SEL_ALL;
            remMask   = dop_pkg::MASK_ALL;
         end
         default: begin
            remChanOk = 1'b0;
         end
      endcase
      // Low byte lands on the addressed port, higher bytes on the ports above it
      remSel   = remSel << remIdx;
      remLines = (remData & remMask)
                 << (int'(remIdx) << dop_pkg::BYTE_SHIFT);
      // Whole command refused if any target port is not an output
      remOk    = remValid && remChanOk && ((remSel & ~dirOut_q) == '0);
   end

   // ==========================================================
   // Panel digit arithmetic
   logic [4:0]                      radix;
   logic [dop_pkg::ACC_WIDTH-1:0]   accNext;
   logic                            digitOk;
   logic [dop_pkg::IDX_WIDTH-1:0]   pnlIdx;
   logic                            pnlWrite;

   always_comb begin
      case (fmt_q)
         dop_pkg::FMT_HEX: radix = dop_pkg::RADIX_HEX;
         dop_pkg::FMT_OCT: radix = dop_pkg::RADIX_OCT;
         default:          radix = dop_pkg::RADIX_DEC;
      endcase
      accNext = dop_pkg::ACC_WIDTH'(acc_q * radix) + dop_pkg::ACC_WIDTH'(panelDigit);
      digitOk = ({1'b0, panelDigit} < radix) && (accNext <= dop_pkg::PANEL_MAX);
      pnlIdx  = chanIndex(panelChan);
      // Remote commands take the cycle; a coincident panel enter is refused
      pnlWrite = panelEnter && !remValid && (pnl_q == dop_pkg::PNL_ENTRY)
                 && chanInRange(panelChan) && dirOut_q[pnlIdx];
   end

   always_comb begin
      pnl_d = pnl_q;
      acc_d = acc_q;
      case (pnl_q)
         dop_pkg::PNL_IDLE: begin
            if (panelDigitValid && digitOk) begin
               acc_d = accNext[dop_pkg::PORT_WIDTH-1:0];
               pnl_d = dop_pkg::PNL_ENTRY;
            end
         end
         dop_pkg::PNL_ENTRY: begin
            if (pnlWrite) begin
               acc_d = dop_pkg::PATTERN_RESET;
               pnl_d = dop_pkg::PNL_IDLE;
            end else if (panelDigitValid && digitOk) begin
               acc_d = accNext[dop_pkg::PORT_WIDTH-1:0];
            end
         end
         default: begin
            pnl_d = dop_pkg::PNL_IDLE;
         end
      endcase
      // Clear, a format change or the reset command abandon the entry
      if (panelClear || panelFmtValid || resetCmd) begin
         acc_d = dop_pkg::PATTERN_RESET;
         pnl_d = dop_pkg::PNL_IDLE;
      end
   end

   // ==========================================================
   // Port direction
   // Out-of-range channel numbers are ignored; configuration has no error answer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dirOut_q <= dop_pkg::DIR_RESET;
      end else if (cfgValid && chanInRange(cfgChan)) begin
         dirOut_q[chanIndex(cfgChan)] <= cfgOutput;
      end
   end

   // ==========================================================
   // Per-port load strobes
   // One remOk gates every port, so a word or double-word cannot load a partial set
   logic [dop_pkg::PORT_COUNT-1:0] remLoad;
   logic [dop_pkg::PORT_COUNT-1:0] pnlLoad;

   genvar s;
   generate
      for (s = 0; s < dop_pkg::PORT_COUNT; s++) begin : g_load
         // Remote has priority, so pnlWrite is already low whenever remOk is high
         assign remLoad[s] = remOk && remSel[s];
         assign pnlLoad[s] = pnlWrite && (pnlIdx == dop_pkg::IDX_WIDTH'(s));
      end
   endgenerate

   // ==========================================================
   // Patterns, one register per port
   genvar p;
   generate
      for (p = 0; p < dop_pkg::PORT_COUNT; p++) begin : g_port
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               pattern_q[p] <= dop_pkg::PATTERN_RESET;
            end else if (remLoad[p]) begin
               // All selected ports load on this same edge
               pattern_q[p] <=
                  remLines[p*dop_pkg::PORT_WIDTH +: dop_pkg::PORT_WIDTH];
            end else if (pnlLoad[p]) begin
               pattern_q[p] <= acc_q;
            end
         end

         // Lines stay undriven while the port is an input
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               lineOut[p*dop_pkg::PORT_WIDTH +: dop_pkg::PORT_WIDTH] <= dop_pkg::PATTERN_RESET;
               lineOe[p*dop_pkg::PORT_WIDTH +: dop_pkg::PORT_WIDTH]  <= dop_pkg::PATTERN_RESET;
            end else begin
               lineOut[p*dop_pkg::PORT_WIDTH +: dop_pkg::PORT_WIDTH] <= pattern_q[p];
               lineOe[p*dop_pkg::PORT_WIDTH +: dop_pkg::PORT_WIDTH]  <=
                  {dop_pkg::PORT_WIDTH{dirOut_q[p]}};
            end
         end
      end
   endgenerate

   // ==========================================================
   // Remote answer
   // One answer per request: ack when every target port took the data, err otherwise
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         remAck <= 1'b0;
         remErr <= 1'b0;
      end else begin
         remAck <= remOk;
         remErr <= remValid && !remOk;
      end
   end

   // ==========================================================
   // Panel format and entry
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fmt_q <= dop_pkg::FMT_DEC;
      end else if (resetCmd) begin
         fmt_q <= dop_pkg::FMT_DEC;
      end else if (panelFmtValid) begin
         // No room to show binary, so binary entry falls back to hex
         fmt_q <= (panelFmtSel == dop_pkg::FMT_BIN) ? dop_pkg::FMT_HEX : panelFmtSel;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pnl_q <= dop_pkg::PNL_IDLE;
         acc_q <= dop_pkg::PATTERN_RESET;
      end else begin
         pnl_q <= pnl_d;
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         panelAck   <= 1'b0;
         panelErr   <= 1'b0;
         panelFmt   <= dop_pkg::FMT_DEC;
         panelValue <= dop_pkg::PATTERN_RESET;
      end else begin
         panelAck   <= pnlWrite;
         panelErr   <= (panelEnter && !pnlWrite)
                       || (panelDigitValid && !digitOk && !panelClear && !panelFmtValid
                           && !resetCmd);
         panelFmt   <= fmt_q;
         panelValue <= acc_q;
      end
   end

endmodule

// [bench/dop_output_ports_properties.sv]
// Concurrent checks on the output pattern ports
`timescale 1ns/100ps
module dop_output_ports_properties (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // Remote write
   input wire logic              remValid,
   input wire dop_pkg::dop_op_t  remOp,
   input wire logic [4:0]        remChan,
   input wire logic [31:0]       remData,
   input wire logic              remAck,
   input wire logic              remErr,
   // Panel
   input wire logic              panelFmtValid,
   input wire logic              resetCmd,
   input wire dop_pkg::dop_fmt_t panelFmt,
   // Lines
   input wire logic [31:0]       lineOut,
   input wire logic [31:0]       lineOe
);
   // ====================
   // Properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic isByte;
   logic isPair;
   logic isAll;
   assign isByte = remValid && remOp == dop_pkg::WRITE_PORT_BYTE_CMD;
   assign isPair = remValid && remOp == dop_pkg::WRITE_PORT_PAIR_CMD;
   assign isAll  = remValid && remOp == dop_pkg::WRITE_ALL_PORTS_CMD;
   property p_byte_range;
      isByte && (remChan < 5'h0B || remChan > 5'h0E) |=> remErr && !remAck; endproperty
   a_byte_range: assert property (p_byte_range) else $error("bad byte channel taken");
   property p_pair_chan;
      isPair && remChan != 5'h0B && remChan != 5'h0D |=> remErr && !remAck; endproperty
   a_pair_chan: assert property (p_pair_chan) else $error("bad word channel taken");
   property p_all_chan; isAll && remChan != 5'h0B |=> remErr && !remAck; endproperty
   a_all_chan: assert property (p_all_chan) else $error("bad dword channel taken");
   property p_byte_map; isByte && remChan == 5'h0B ##1 remAck
      |=> lineOut == {$past(lineOut[31:8]), $past(remData[7:0], 2)}; endproperty
   a_byte_map: assert property (p_byte_map) else $error("byte lines wrong");
   property p_pair_low; isPair && remChan == 5'h0B ##1 remAck
      |=> lineOut == {$past(lineOut[31:16]), $past(remData[15:0], 2)}; endproperty
   a_pair_low: assert property (p_pair_low) else $error("low word lines wrong");
   property p_pair_high; isPair && remChan == 5'h0D ##1 remAck
      |=> lineOut == {$past(remData[15:0], 2), $past(lineOut[15:0])}; endproperty
   a_pair_high: assert property (p_pair_high) else $error("high word lines wrong");
   property p_all_map; isAll ##1 remAck |=> lineOut == $past(remData, 2); endproperty
   a_all_map: assert property (p_all_map) else $error("dword lines wrong");
   property p_input_hold; !lineOe[31] && !$fell(lineOe[31]) |-> $stable(lineOut[31:24]);
   endproperty
   a_input_hold: assert property (p_input_hold) else $error("input port lines moved");
   property p_fmt_dec;
      resetCmd && !panelFmtValid |-> ##[1:2] panelFmt == dop_pkg::FMT_DEC; endproperty
   a_fmt_dec: assert property (p_fmt_dec) else $error("format not decimal");
   c_all: cover property (isAll ##1 remAck);
   c_pair_err: cover property (isPair ##1 remErr);
   c_reset_cmd: cover property (resetCmd);
endmodule

// [bench/dop_line_load.sv]
// Load on the output lines
`timescale 1ns/100ps
module dop_line_load (
   // Lines from the ports
   input  wire logic [31:0] lineOut,
   input  wire logic [31:0] lineOe,
   // Level seen at the load
   output logic      [31:0] lineLevel
);
   // Pull-downs hold a released line at ground, so a stale level never shows
   assign lineLevel = lineOut & lineOe;
endmodule

// [bench/dop_output_ports_tb.sv]
// Self-checking bench for the output pattern ports
`timescale 1ns/100ps
module dop_output_ports_tb;
   logic mclk, rst, cfgValid, cfgOutput, remValid, remAck, remErr;
   logic panelFmtValid, panelDigitValid, panelClear, panelEnter, resetCmd, panelAck, panelErr;
   logic [4:0] cfgChan, remChan, panelChan;
   logic [3:0] panelDigit;
   logic [7:0] panelValue;
   logic [31:0] remData, lineOut, lineOe, lineLevel, expLvl;
   dop_pkg::dop_op_t remOp;
   dop_pkg::dop_fmt_t panelFmtSel, panelFmt;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   dop_output_ports dut (.mclk, .rst, .cfgValid, .cfgChan, .cfgOutput, .remValid, .remOp,
      .remChan, .remData, .remAck, .remErr, .panelFmtValid, .panelFmtSel, .panelDigitValid,
      .panelDigit, .panelClear, .panelEnter, .panelChan, .resetCmd, .panelAck, .panelErr,
      .panelFmt, .panelValue, .lineOut, .lineOe);
   dop_line_load load (.lineOut, .lineOe, .lineLevel);
   // ====================
   // Helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfg(input logic [4:0] ch, input logic out);
      @(negedge mclk);
      cfgValid = 1'h1;
      cfgChan = ch;
      cfgOutput = out;
      @(negedge mclk);
      cfgValid = 1'h0;
      @(negedge mclk);
   endtask
   task automatic rem(input dop_pkg::dop_op_t op, input logic [4:0] ch, input logic [31:0] d,
                      input logic ok);
      @(negedge mclk);
      remValid = 1'h1;
      remOp = op;
      remChan = ch;
      remData = d;
      @(negedge mclk);
      chk("remAck", 32'(ok), 32'(remAck));
      chk("remErr", 32'(!ok), 32'(remErr));
      remValid = 1'h0;
      remData = ~d;
      @(negedge mclk);
      chk("lineLevel", expLvl, lineLevel);
   endtask
   task automatic pnl(input logic [3:0] dg, input logic dv, input logic en, input logic rc);
      @(negedge mclk);
      panelDigitValid = dv;
      panelDigit = dg;
      panelEnter = en;
      resetCmd = rc;
      @(negedge mclk);
      {panelDigitValid, panelEnter, resetCmd} = 3'h0;
   endtask
   task automatic digs(input logic [11:0] ds, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         pnl(ds[4*i+:4], 1'h1, 1'h0, 1'h0);
      end
   endtask
   task automatic ent(input logic [4:0] ch);
      panelChan = ch;
      pnl(4'h0, 1'h0, 1'h1, 1'h0);
      chk("panelAck", 32'h1, 32'(panelAck));
      @(negedge mclk);
      chk("lineLevel", expLvl, lineLevel);
   endtask
   task automatic fmt(input dop_pkg::dop_fmt_t f);
      @(negedge mclk);
      panelFmtValid = 1'h1;
      panelFmtSel = f;
      @(negedge mclk);
      panelFmtValid = 1'h0;
   endtask
   // ====================
   // Scenarios
   task automatic t_unconfigured;
      chk("panelFmt", 32'(dop_pkg::FMT_DEC), 32'(panelFmt));
      rem(dop_pkg::WRITE_PORT_BYTE_CMD, 5'h0B, 32'hFF, 1'h0);
      for (int k = 0; k < 5; k++) begin
         cfg(5'h0B + 5'(k), 1'h1);
      end
      chk("lineOe", 32'hFFFF_FFFF, lineOe);
   endtask
   task automatic t_bytes;
      for (int k = 0; k < 4; k++) begin
         expLvl[8*k+:8] = 8'hA5 + 8'(k * 17);
         rem(dop_pkg::WRITE_PORT_BYTE_CMD, 5'h0B + 5'(k), {24'hFFFFFF, expLvl[8*k+:8]}, 1'h1);
      end
      rem(dop_pkg::WRITE_PORT_BYTE_CMD, 5'h0A, 32'h0, 1'h0);
      rem(dop_pkg::WRITE_PORT_BYTE_CMD, 5'h0F, 32'h0, 1'h0);
   endtask
   task automatic t_words;
      expLvl[15:0] = 16'h8001;
      rem(dop_pkg::WRITE_PORT_PAIR_CMD, 5'h0B, 32'hFFFF_8001, 1'h1);
      expLvl[31:16] = 16'hA5C3;
      rem(dop_pkg::WRITE_PORT_PAIR_CMD, 5'h0D, 32'h0000_A5C3, 1'h1);
      rem(dop_pkg::WRITE_PORT_PAIR_CMD, 5'h0C, 32'h0, 1'h0);
      rem(dop_pkg::WRITE_PORT_PAIR_CMD, 5'h0E, 32'h0, 1'h0);
   endtask
   task automatic t_dword;
      expLvl = 32'h8421_1248;
      rem(dop_pkg::WRITE_ALL_PORTS_CMD, 5'h0B, expLvl, 1'h1);
      rem(dop_pkg::WRITE_ALL_PORTS_CMD, 5'h0D, 32'h0, 1'h0);
      rem(dop_pkg::WRITE_NONE_CMD, 5'h0B, 32'h0, 1'h0);
   endtask
   task automatic t_panel;
      digs(12'h165, 3);
      @(negedge mclk);
      chk("panelValue", 32'hA5, 32'(panelValue));
      expLvl[15:8] = 8'hA5;
      ent(5'h0C);
      fmt(dop_pkg::FMT_BIN);
      @(negedge mclk);
      chk("panelFmt", 32'(dop_pkg::FMT_HEX), 32'(panelFmt));
      digs(12'h0F0, 2);
      expLvl[31:24] = 8'hF0;
      ent(5'h0E);
      fmt(dop_pkg::FMT_OCT);
      digs(12'h377, 3);
      expLvl[23:16] = 8'hFF;
      ent(5'h0D);
      pnl(4'h8, 1'h1, 1'h0, 1'h0);
      chk("panelErr", 32'h1, 32'(panelErr));
      pnl(4'h0, 1'h0, 1'h0, 1'h1);
      @(negedge mclk);
      chk("panelFmt", 32'(dop_pkg::FMT_DEC), 32'(panelFmt));
      pnl(4'hA, 1'h1, 1'h0, 1'h0);
      chk("panelErr", 32'h1, 32'(panelErr));
      digs(12'h007, 1);
      @(negedge mclk);
      panelClear = 1'h1;
      @(negedge mclk);
      panelClear = 1'h0;
      pnl(4'h0, 1'h0, 1'h1, 1'h0);
      chk("panelErr", 32'h1, 32'(panelErr));
   endtask
   task automatic t_input;
      cfg(5'h0E, 1'h0);
      expLvl[31:24] = 8'h00;
      chk("lineOe", 32'h00FF_FFFF, lineOe);
      rem(dop_pkg::WRITE_PORT_BYTE_CMD, 5'h0E, 32'h3C, 1'h0);
      rem(dop_pkg::WRITE_ALL_PORTS_CMD, 5'h0B, 32'h0, 1'h0);
   endtask
   task automatic final_report;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ====================
   // Clock, reset, sequence
   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         final_report;
      end
   end
   initial begin
      {cfgValid, cfgOutput, remValid, panelFmtValid, panelDigitValid, panelClear} = 6'h0;
      {panelEnter, resetCmd, cfgChan, remChan, panelChan, panelDigit, remData} = '0;
      remOp = dop_pkg::WRITE_NONE_CMD;
      panelFmtSel = dop_pkg::FMT_DEC;
      expLvl = 32'h0;
      rst = 1'h1;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'h0;
      t_unconfigured;
      t_bytes;
      t_words;
      t_dword;
      t_panel;
      t_input;
      final_report;
   end
endmodule
bind dop_output_ports dop_output_ports_properties chk (.mclk, .rst, .remValid, .remOp, .remChan,
   .remData, .remAck, .remErr, .panelFmtValid, .resetCmd, .panelFmt, .lineOut, .lineOe);
